// ---- src/rsef_pkg.sv ----
// Types shared by the error flag block and its bench.
// Assumes an 8-bit register data path and byte addressing.
package rsef_pkg;
    typedef logic [7:0] rsef_byte_t;
    typedef logic [7:0] rsef_addr_t;
    typedef logic [5:0] rsef_idx_t;
endpackage : rsef_pkg

// ---- src/rsef_regs.svh ----
// Register map and bit layout of the receiver/converter error flags.
// Included by the flag block and its bench; definitions only.
`ifndef RSEF_REGS_SVH
`define RSEF_REGS_SVH

// Register indices; byte address is four times the index
`define RSEF_IDX_RX_FLAGS   6'h18
`define RSEF_IDX_RX_EN      6'h19
`define RSEF_IDX_CV_FLAGS   6'h1A
`define RSEF_IDX_CV_EN      6'h1B
`define RSEF_IDX_TOP        6'h1C
`define RSEF_IDX_TOP_EN     6'h1D

// Receiver flag bit positions
`define RSEF_RX_VALID       7
`define RSEF_RX_PREEMPH     6
`define RSEF_RX_COMPRESSED  5
`define RSEF_RX_BURST       4
`define RSEF_RX_CHECKSUM    3
`define RSEF_RX_ABSENT      2
`define RSEF_RX_CODING      1
`define RSEF_RX_LOCK        0

// Converter flag bit positions
`define RSEF_CV_SHORT       3
`define RSEF_CV_LCLIP       2
`define RSEF_CV_RCLIP       1
`define RSEF_CV_FAST        0

// Top-level summary bit positions
`define RSEF_TOP_CV         7
`define RSEF_TOP_RX         0

// Flag kinds and implemented bits
`define RSEF_RX_STICKY      8'h0A
`define RSEF_RX_STATE       8'hF5
`define RSEF_CV_STICKY      8'h0E
`define RSEF_CV_STATE       8'h01
`define RSEF_CV_EN_USED     8'h07
`define RSEF_TOP_USED       8'h81

// Reset values
`define RSEF_RX_EN_RST      8'h00
`define RSEF_CV_EN_RST      8'h00
`define RSEF_TOP_EN_RST     8'h00
`define RSEF_FLAG_RST       8'h00

`endif

// ---- src/rsef_top.sv ----
// Receiver and converter error flags with masks and interrupt summary.
// Assumes status inputs synchronous to mclk and an Avalon-MM master.
`timescale 1ns/1ps
`include "rsef_regs.svh"

module rsef_top (
    input  wire logic                 mclk,
    input  wire logic                 srst,
    input  wire rsef_pkg::rsef_addr_t avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire rsef_pkg::rsef_byte_t avs_writedata,
    output rsef_pkg::rsef_byte_t      avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic                 received_valid_flag,
    input  wire logic                 preemph_flag,
    input  wire logic                 compressed_payload_flag,
    input  wire logic                 nonaudio_type_change,
    input  wire logic                 burst_preamble_flag,
    input  wire logic                 cs_checksum_fail,
    input  wire logic                 input_absent,
    input  wire logic                 coding_parity_fail,
    input  wire logic                 pll_locked,
    input  wire logic                 converter_clock_short,
    input  wire logic                 left_clip_flag,
    input  wire logic                 right_clip_flag,
    input  wire logic                 fast_mode_mute_hint,
    output logic                      irq
);
    import rsef_pkg::*;

    // Bus handshake: one wait cycle, then accept
    logic       ack_reg;
    rsef_byte_t rdata_reg;
    wire        req_any = avs_read | avs_write;
    wire        cap     = req_any & ~ack_reg;
    wire        done    = req_any & ack_reg;
    wire        rd_cap  = avs_read & cap;
    wire        wr_done = avs_write & done;

    wire        aligned = (avs_address[1:0] == 2'h0);
    rsef_idx_t  idx;
    assign idx = avs_address[7:2];

    wire sel_rx     = aligned & (idx == `RSEF_IDX_RX_FLAGS);
    wire sel_rx_en  = aligned & (idx == `RSEF_IDX_RX_EN);
    wire sel_cv     = aligned & (idx == `RSEF_IDX_CV_FLAGS);
    wire sel_cv_en  = aligned & (idx == `RSEF_IDX_CV_EN);
    wire sel_top    = aligned & (idx == `RSEF_IDX_TOP);
    wire sel_top_en = aligned & (idx == `RSEF_IDX_TOP_EN);

    // Read side effects act on the capture edge, so a flag that sets
    // after the snapshot is kept for the next read instead of lost
    wire rd_rx  = rd_cap & sel_rx;
    wire rd_cv  = rd_cap & sel_cv;
    wire rd_top = rd_cap & sel_top;
    wire wr_top = wr_done & sel_top;

    // Wait drops in the second cycle whatever the address, so a master
    // never hangs on an unmapped or misaligned access
    assign avs_waitrequest = cap;
    assign avs_readdata    = rdata_reg;

    // Receiver flags
    rsef_byte_t rx_stk_reg;
    rsef_byte_t rx_stk_next;
    rsef_byte_t rx_seen_reg;
    rsef_byte_t rx_en_reg;
    logic       rx_type_reg;
    logic       rx_type_next;
    rsef_byte_t rx_live;
    rsef_byte_t rx_set;
    rsef_byte_t rx_clr;
    rsef_byte_t rx_evt;
    rsef_byte_t rx_flags;

    assign rx_live = {received_valid_flag,
                      preemph_flag,
                      compressed_payload_flag,
                      burst_preamble_flag,
                      1'b0,
                      input_absent,
                      1'b0,
                      pll_locked};

    assign rx_set = {4'h0, cs_checksum_fail, 1'b0,
                     coding_parity_fail, 1'b0};
    assign rx_clr = rd_rx ? `RSEF_RX_STICKY : 8'h00;

    // Set wins over the read clear
    assign rx_stk_next = (rx_stk_reg & ~rx_clr) | rx_set;
    // The type change arrives as a pulse; it is held until the next read
    // because the nonaudio level alone cannot show a change of type
    assign rx_type_next = (rx_type_reg & ~rd_rx)
                        | nonaudio_type_change;

    // Event pending while a state flag differs from its value at
    // the last read of the register
    assign rx_evt = ((rx_live ^ rx_seen_reg) & `RSEF_RX_STATE)
                  | rx_stk_reg
                  | {2'b00, rx_type_reg, 5'h00};

    assign rx_flags = (rx_live & `RSEF_RX_STATE) | rx_stk_reg;

    wire rx_hit = |(rx_evt & rx_en_reg);

    // Converter flags
    rsef_byte_t cv_stk_reg;
    rsef_byte_t cv_stk_next;
    rsef_byte_t cv_seen_reg;
    rsef_byte_t cv_en_reg;
    rsef_byte_t cv_live;
    rsef_byte_t cv_set;
    rsef_byte_t cv_clr;
    rsef_byte_t cv_evt;
    rsef_byte_t cv_flags;

    assign cv_live = {7'h00, fast_mode_mute_hint};
    assign cv_set  = {4'h0,
                      converter_clock_short,
                      left_clip_flag,
                      right_clip_flag,
                      1'b0};
    assign cv_clr = rd_cv ? `RSEF_CV_STICKY : 8'h00;
    assign cv_stk_next = (cv_stk_reg & ~cv_clr) | cv_set;

    assign cv_evt = ((cv_live ^ cv_seen_reg) & `RSEF_CV_STATE)
                  | cv_stk_reg;
    assign cv_flags = (cv_live & `RSEF_CV_STATE) | cv_stk_reg;

    // Clock-short has no enable bit, so it never interrupts
    wire cv_hit = |(cv_evt & cv_en_reg & `RSEF_CV_EN_USED);

    // Top-level summary: read clears, write-one clears, set wins
    rsef_byte_t top_reg;
    rsef_byte_t top_next;
    rsef_byte_t top_en_reg;
    rsef_byte_t top_set;
    rsef_byte_t top_clr;

    assign top_set = {cv_hit, 6'h00, rx_hit};
    assign top_clr = rd_top ? `RSEF_TOP_USED
                   : (wr_done & sel_top) ?
                     (avs_writedata & `RSEF_TOP_USED) : 8'h00;
    assign top_next = (top_reg & ~top_clr) | top_set;

    assign irq = |(top_reg & top_en_reg);

    // Read mux; unmapped addresses read as zero
    rsef_byte_t rd_mux;
    assign rd_mux = sel_rx     ? rx_flags :
                    sel_rx_en  ? rx_en_reg :
                    sel_cv     ? cv_flags :
                    sel_cv_en  ? cv_en_reg :
                    sel_top    ? top_reg :
                    sel_top_en ? top_en_reg : 8'h00;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ack_reg <= cap;
            if (rd_cap) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_stk_reg  <= `RSEF_FLAG_RST;
            rx_seen_reg <= `RSEF_FLAG_RST;
            rx_type_reg <= 1'b0;
            cv_stk_reg  <= `RSEF_FLAG_RST;
            cv_seen_reg <= `RSEF_FLAG_RST;
            top_reg     <= `RSEF_FLAG_RST;
        end else begin
            rx_stk_reg  <= rx_stk_next;
            rx_type_reg <= rx_type_next;
            cv_stk_reg  <= cv_stk_next;
            top_reg     <= top_next;
            if (rd_rx) begin
                rx_seen_reg <= rx_live & `RSEF_RX_STATE;
            end
            if (rd_cv) begin
                cv_seen_reg <= cv_live & `RSEF_CV_STATE;
            end
        end
    end

    // Writes to the flag registers have no path here
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_en_reg  <= `RSEF_RX_EN_RST;
            cv_en_reg  <= `RSEF_CV_EN_RST;
            top_en_reg <= `RSEF_TOP_EN_RST;
        end else if (wr_done) begin
            if (sel_rx_en) begin
                rx_en_reg <= avs_writedata;
            end
            if (sel_cv_en) begin
                cv_en_reg <= avs_writedata & `RSEF_CV_EN_USED;
            end
            if (sel_top_en) begin
                top_en_reg <= avs_writedata & `RSEF_TOP_USED;
            end
        end
    end

    // Checks run on the bus clock and sleep while reset is held
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_rx_valid_bit: assert property (
        rd_rx |=> avs_readdata[`RSEF_RX_VALID] == $past(received_valid_flag)
    ) else $error("validity bit not mirrored");

    a_checksum_sticky: assert property (
        cs_checksum_fail ##1 (!rd_rx)[*3] |=> rx_flags[`RSEF_RX_CHECKSUM]
    ) else $error("checksum flag lost before read");

    a_coding_sticky: assert property (
        coding_parity_fail ##1 (!rd_rx)[*2] |=> rx_flags[`RSEF_RX_CODING]
    ) else $error("coding flag lost before read");

    a_rx_read_clear: assert property (
        rd_rx && !cs_checksum_fail && !coding_parity_fail
        |=> !rx_stk_reg[`RSEF_RX_CHECKSUM] && !rx_stk_reg[`RSEF_RX_CODING]
    ) else $error("sticky receiver flags not cleared by read");

    a_lock_event: assert property (
        rd_rx |=> rx_evt[`RSEF_RX_LOCK]
                  == (pll_locked != $past(pll_locked))
    ) else $error("lock event not relative to last read");

    a_rx_mask_gate: assert property (
        (rx_en_reg == 8'h00) && !top_reg[`RSEF_TOP_RX] && $stable(rx_en_reg)
        |=> !top_reg[`RSEF_TOP_RX]
    ) else $error("masked receiver event raised summary");

    a_rx_summary: assert property (
        |(rx_evt & rx_en_reg) |=> top_reg[`RSEF_TOP_RX]
    ) else $error("receiver summary not set");

    a_cv_summary: assert property (
        |(cv_evt & cv_en_reg & `RSEF_CV_EN_USED)
        |=> top_reg[`RSEF_TOP_CV] ##1
            (top_reg[`RSEF_TOP_CV] || $past(rd_top) || $past(wr_top))
    ) else $error("converter summary not set or dropped");

    a_top_read_clr: assert property (
        rd_top && !cv_hit |=> !top_reg[`RSEF_TOP_CV]
    ) else $error("summary not cleared by status read");

    a_ro_flags: assert property (
        wr_done && (sel_rx || sel_cv) && !(|rx_set) && !(|cv_set)
        |=> rx_stk_reg == $past(rx_stk_reg) && cv_stk_reg == $past(cv_stk_reg)
    ) else $error("write altered a read-only flag");

    a_lclip_sticky: assert property (
        left_clip_flag ##1 (!rd_cv)[*2] |=> cv_flags[`RSEF_CV_LCLIP]
    ) else $error("left clip flag lost before read");

    a_rclip_sticky: assert property (
        right_clip_flag ##1 !rd_cv |=> cv_flags[`RSEF_CV_RCLIP]
    ) else $error("right clip flag lost before read");

    a_bus_answer: assert property (
        cap |=> !avs_waitrequest
    ) else $error("request not answered after one wait cycle");

    a_wr_answer: assert property (
        wr_done |-> !avs_waitrequest
    ) else $error("write completed while wait was requested");

    a_rdata_hold: assert property (
        !rd_cap |=> $stable(avs_readdata)
    ) else $error("read data changed outside a read");

    // Live bits read back as sampled at the capture edge
    a_lock_bit: assert property (
        rd_rx |=> avs_readdata[`RSEF_RX_LOCK] == $past(pll_locked)
    ) else $error("lock bit not shown on read");

    a_absent_bit: assert property (
        rd_rx |=> avs_readdata[`RSEF_RX_ABSENT] == $past(input_absent)
    ) else $error("absent bit not shown on read");

    // State events are measured against the snapshot of the last read
    a_valid_event: assert property (
        rd_rx |=> rx_evt[`RSEF_RX_VALID]
                  == (received_valid_flag != $past(received_valid_flag))
    ) else $error("validity event not relative to last read");

    a_preemph_event: assert property (
        rd_rx |=> rx_evt[`RSEF_RX_PREEMPH]
                  == (preemph_flag != $past(preemph_flag))
    ) else $error("pre-emphasis event not relative to last read");

    a_burst_event: assert property (
        rd_rx |=> rx_evt[`RSEF_RX_BURST]
                  == (burst_preamble_flag != $past(burst_preamble_flag))
    ) else $error("burst event not relative to last read");

    a_absent_event: assert property (
        rd_rx |=> rx_evt[`RSEF_RX_ABSENT]
                  == (input_absent != $past(input_absent))
    ) else $error("absent event not relative to last read");

    a_type_event: assert property (
        nonaudio_type_change |=> rx_evt[`RSEF_RX_COMPRESSED]
    ) else $error("nonaudio type change raised no event");

    a_type_clear: assert property (
        rd_rx && !nonaudio_type_change |=> !rx_type_reg
    ) else $error("type change event kept after read");

    // Converter side
    a_fast_event: assert property (
        rd_cv |=> cv_evt[`RSEF_CV_FAST]
                  == (fast_mode_mute_hint != $past(fast_mode_mute_hint))
    ) else $error("fast mode event not relative to last read");

    a_short_sticky: assert property (
        converter_clock_short ##1 !rd_cv |=> cv_flags[`RSEF_CV_SHORT]
    ) else $error("clock short flag lost before read");

    a_cv_read_clear: assert property (
        rd_cv && !converter_clock_short
        && !left_clip_flag && !right_clip_flag
        |=> cv_stk_reg == 8'h00
    ) else $error("sticky converter flags not cleared by read");

    a_cv_mask_bits: assert property (
        (cv_en_reg & ~`RSEF_CV_EN_USED) == 8'h00
    ) else $error("converter mask holds an unimplemented enable");

    // Summary and interrupt output
    a_irq_level: assert property (
        top_reg[`RSEF_TOP_RX] && top_en_reg[`RSEF_TOP_RX] |-> irq
    ) else $error("enabled receiver summary did not raise irq");

    a_top_w1c: assert property (
        wr_top && avs_writedata[`RSEF_TOP_RX] && !rx_hit
        |=> !top_reg[`RSEF_TOP_RX]
    ) else $error("write of one did not clear receiver summary");

    a_rx_hold: assert property (
        top_reg[`RSEF_TOP_RX] && !rd_top && !wr_top
        |=> top_reg[`RSEF_TOP_RX]
    ) else $error("receiver summary dropped before status read");

    a_mask_write: assert property (
        wr_done && sel_rx_en |=> rx_en_reg == $past(avs_writedata)
    ) else $error("receiver mask write not applied");

endmodule : rsef_top

// ---- tb/rsef_testbench.sv ----
// Self-checking bench for the receiver/converter error flag block.
// Assumes rsef_top with an Avalon-MM slave needing one wait cycle.
`timescale 1ns/1ps
`include "rsef_regs.svh"
module testbench;
    import rsef_pkg::*;
    localparam rsef_addr_t A_RXF  = {`RSEF_IDX_RX_FLAGS, 2'b00};
    localparam rsef_addr_t A_RXE  = {`RSEF_IDX_RX_EN, 2'b00};
    localparam rsef_addr_t A_CVF  = {`RSEF_IDX_CV_FLAGS, 2'b00};
    localparam rsef_addr_t A_CVE  = {`RSEF_IDX_CV_EN, 2'b00};
    localparam rsef_addr_t A_TOP  = {`RSEF_IDX_TOP, 2'b00};
    localparam rsef_addr_t A_TOPE = {`RSEF_IDX_TOP_EN, 2'b00};
    localparam rsef_addr_t A_BAD  = 8'h00;
    logic       mclk, srst, avs_read, avs_write, avs_waitrequest, irq;
    rsef_addr_t avs_address;
    rsef_byte_t avs_writedata, avs_readdata, q;
    logic       vld, pre, cmp, typ, bst, crc, abs, cod, lck;
    logic       shrt, lcl, rcl, fst;
    int         n_mismatch, comparisons;

    rsef_top dut (
        .mclk(mclk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .received_valid_flag(vld),
        .preemph_flag(pre), .compressed_payload_flag(cmp),
        .nonaudio_type_change(typ), .burst_preamble_flag(bst),
        .cs_checksum_fail(crc), .input_absent(abs),
        .coding_parity_fail(cod), .pll_locked(lck),
        .converter_clock_short(shrt), .left_clip_flag(lcl),
        .right_clip_flag(rcl), .fast_mode_mute_hint(fst), .irq(irq)
    );

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task results;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task chk(input rsef_byte_t got, input rsef_byte_t exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low at a rising edge
    task xfer(input logic w, input rsef_addr_t a, input rsef_byte_t d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= ~w;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        if (n >= 20) begin
            n_mismatch++;
            results;
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : xfer

    task wr(input rsef_addr_t a, input rsef_byte_t d);
        xfer(1'b1, a, d);
    endtask : wr

    task rd(input rsef_addr_t a, input rsef_byte_t e);
        xfer(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rd

    // Waits a bounded time for irq to reach the expected level
    task see_irq(input logic e);
        int n;
        for (n = 0; n < 8 && irq !== e; n++) @(posedge mclk);
        chk({7'h00, irq}, {7'h00, e});
    endtask : see_irq

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        results;
    end

    initial begin
        n_mismatch = 0;
        comparisons = 0;
        srst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        {vld, pre, cmp, typ, bst, crc, abs, cod, lck} = '0;
        {shrt, lcl, rcl, fst} = '0;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(A_RXE, 8'h00);
        rd(A_CVE, 8'h00);
        see_irq(1'b0);
        wr(A_RXE, 8'hA5);
        rd(A_RXE, 8'hA5);
        wr(A_CVE, 8'hFF);
        rd(A_CVE, 8'h07);
        wr(A_BAD, 8'hFF);
        rd(A_BAD, 8'h00);
        wr(A_RXE, 8'h00);
        wr(A_CVE, 8'h00);
        {vld, pre, cmp, bst, abs, lck} <= 6'h3F;
        {crc, cod, shrt, lcl, rcl, fst} <= 6'h3F;
        @(posedge mclk);
        {crc, cod, shrt, lcl, rcl} <= 5'h00;
        @(posedge mclk);
        // Stickies must survive a write of ones to the read-only flags
        wr(A_RXF, 8'hFF);
        wr(A_CVF, 8'hFF);
        rd(A_RXF, 8'hFF);
        rd(A_RXF, 8'hF5);
        rd(A_CVF, 8'h0F);
        rd(A_CVF, 8'h01);
        rd(A_TOP, 8'h00);
        wr(A_TOPE, 8'h81);
        lck <= 1'b0;
        repeat (4) @(posedge mclk);
        see_irq(1'b0);
        rd(A_RXF, 8'hF4);
        rd(A_TOP, 8'h00);
        wr(A_RXE, 8'h01);
        lck <= 1'b1;
        see_irq(1'b1);
        rd(A_RXF, 8'hF5);
        rd(A_TOP, 8'h01);
        see_irq(1'b0);
        wr(A_RXE, 8'h20);
        typ <= 1'b1;
        @(posedge mclk);
        typ <= 1'b0;
        see_irq(1'b1);
        rd(A_RXF, 8'hF5);
        rd(A_TOP, 8'h01);
        see_irq(1'b0);
        wr(A_CVE, 8'h04);
        lcl <= 1'b1;
        @(posedge mclk);
        lcl <= 1'b0;
        see_irq(1'b1);
        rd(A_CVF, 8'h05);
        rd(A_TOP, 8'h80);
        see_irq(1'b0);
        // Summary bit sets even with its top-level enable cleared
        wr(A_TOPE, 8'h01);
        wr(A_CVE, 8'h01);
        fst <= 1'b0;
        repeat (4) @(posedge mclk);
        see_irq(1'b0);
        rd(A_CVF, 8'h00);
        rd(A_TOP, 8'h80);
        rd(A_TOP, 8'h00);
        // Sticky event, then the summary cleared by a write of one
        wr(A_RXE, 8'h0C);
        wr(A_TOPE, 8'h81);
        crc <= 1'b1;
        @(posedge mclk);
        crc <= 1'b0;
        see_irq(1'b1);
        rd(A_RXF, 8'hFD);
        wr(A_TOP, 8'h01);
        see_irq(1'b0);
        rd(A_TOP, 8'h00);
        abs <= 1'b0;
        see_irq(1'b1);
        rd(A_RXF, 8'hF1);
        rd(A_TOP, 8'h01);
        see_irq(1'b0);
        // Reset in mid-run must bring the receiver mask and summary back to zero
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(A_RXE, 8'h00);
        rd(A_TOP, 8'h00);
        rd(A_RXF, 8'hF1);
        results;
    end
endmodule : testbench
